/* btb_consts.vh */
`ifndef BTB_CONSTS_VH
`define BTB_CONSTS_VH

// Operation codes on the request port
`define BTB_OP_NOP        4'h0
`define BTB_OP_BT         4'h1
`define BTB_OP_BF         4'h2
`define BTB_OP_BRANCH_SET_THEN_CLEAR      4'h3
`define BTB_OP_DECREMENT_BRANCH_NONZERO       4'h4
`define BTB_OP_SEL        4'h5
`define BTB_OP_EI         4'h6
`define BTB_OP_DI         4'h7
`define BTB_OP_HALT       4'h8
`define BTB_OP_STOP       4'h9

// Operand kinds on the request port
`define BTB_K_SADDR       3'h0
`define BTB_K_SFR         3'h1
`define BTB_K_ACC         3'h2
`define BTB_K_PSW         3'h3
`define BTB_K_HL          3'h4
`define BTB_K_REGB        3'h5
`define BTB_K_REGC        3'h6

// Instruction lengths in bytes
`define BTB_LEN1          16'h0001
`define BTB_LEN2          16'h0002
`define BTB_LEN3          16'h0003
`define BTB_LEN4          16'h0004

// Cycle counts in CPU clock periods
`define BTB_CYC2          5'h02
`define BTB_CYC4          5'h04
`define BTB_CYC6          5'h06
`define BTB_CYC8          5'h08
`define BTB_CYC9          5'h09
`define BTB_CYC10         5'h0A
`define BTB_CYC11         5'h0B
`define BTB_CYC12         5'h0C
// Extra cycles when the program is not fetched from internal ROM
`define BTB_EXT_FETCH     5'h02

// Register offsets on the software port
`define BTB_ADDR_ACC      4'h0
`define BTB_ADDR_REGB     4'h1
`define BTB_ADDR_REGC     4'h2
`define BTB_ADDR_PSW      4'h3
`define BTB_ADDR_PCC      4'h4
`define BTB_ADDR_STAT     4'h5
`define BTB_ADDR_PCL      4'h6
`define BTB_ADDR_PCH      4'h7

// Status word field positions
`define BTB_PSW_IE        7
`define BTB_PSW_BANK1     5
`define BTB_PSW_BANK0     3

// Status register field positions
`define BTB_ST_BUSY       0
`define BTB_ST_HALT       1
`define BTB_ST_STOP       2
`define BTB_ST_TAKEN      3

// Reset values
`define BTB_RST_BYTE      8'h00
`define BTB_RST_PSW       8'h02
`define BTB_RST_PC        16'h0000
`define BTB_RST_PCC       3'h0

`endif

/* btb_cpu_tick.v */
`timescale 1ns/100ps
// Divides the system clock into CPU clock ticks as the clock control selects
module btb_cpu_tick (
  // Clock and reset
  input  wire       mclk_i,
  input  wire       rst_n_i,
  // Divider select, 0 = every clock, n = every 2^n clocks, 4 and up = 16
  input  wire [2:0] div_sel_i,
  // One-cycle tick per CPU clock period
  output wire       tick_o
);

  reg  [3:0] div_cnt;
  reg  [3:0] mask;

  // Mask of the low counter bits that must all be set for a tick
  always @* begin
    case (div_sel_i)
      3'h0:    mask = 4'h0;
      3'h1:    mask = 4'h1;
      3'h2:    mask = 4'h3;
      3'h3:    mask = 4'h7;
      default: mask = 4'hF;
    endcase
  end

  // Free-running count; a changed select takes effect within one wrap
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      div_cnt <= 4'h0;
    end else begin
      div_cnt <= div_cnt + 4'h1;
    end
  end

  assign tick_o = &(div_cnt | ~mask);

endmodule

/* btb_exec.v */
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/100ps
`include "btb_consts.vh"

module btb_exec (
  // Clock and reset
  input  wire        mclk_i,
  input  wire        rst_n_i,
  // Software register port
  input  wire [3:0]  reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [7:0]  reg_rdata_o,
  // Instruction request from the sequencer
  input  wire        req_i,
  input  wire [3:0]  req_op_i,
  input  wire [2:0]  req_kind_i,
  input  wire [2:0]  req_bit_i,
  input  wire [7:0]  req_disp_i,
  input  wire [7:0]  req_opr_i,
  input  wire        req_fast_ram_i,
  input  wire        req_rom_fetch_i,
  output wire        ready_o,
  // Completion
  output reg         done_o,
  output reg         taken_o,
  output reg  [7:0]  wb_data_o,
  output reg         wb_en_o,
  // Core state
  output wire [15:0] pc_o,
  output wire [7:0]  psw_o,
  output wire        halt_o,
  output wire        stop_o
);

  // Architectural state
  reg  [7:0]  acc;
  reg  [7:0]  reg_b;
  reg  [7:0]  reg_c;
  reg  [7:0]  program_status_word;
  reg  [15:0] pc;
  reg  [2:0]  processor_clock_control;
  reg         halt_mode;
  reg         stop_mode;
  reg         last_taken;

  // Latched request
  reg         busy;
  reg  [3:0]  op;
  reg  [2:0]  kind;
  reg  [2:0]  bitn;
  reg  [7:0]  disp;
  reg  [7:0]  opr;
  reg  [4:0]  cyc_cnt;

  // Next values
  reg  [7:0]  next_acc;
  reg  [7:0]  next_reg_b;
  reg  [7:0]  next_reg_c;
  reg  [7:0]  next_psw;
  reg  [15:0] next_pc;
  reg         next_halt;
  reg         next_stop;

  // Execution terms
  wire        tick;
  wire        finish;
  reg  [7:0]  src;
  reg         taken;
  reg  [7:0]  dec_val;
  reg  [7:0]  clr_val;
  reg         ext_wb;
  reg  [7:0]  ext_wb_data;
  wire [15:0] disp_ext;
  wire [15:0] seq_pc;

  // Length in bytes of each instruction form
  function [15:0] instr_len;
    input [3:0] f_op;
    input [2:0] f_kind;
    begin
      case (f_op)
        `BTB_OP_BT: begin
          instr_len = (f_kind == `BTB_K_SFR) ? `BTB_LEN4 : `BTB_LEN3;
        end
        `BTB_OP_BF, `BTB_OP_BRANCH_SET_THEN_CLEAR: begin
          if ((f_kind == `BTB_K_ACC) || (f_kind == `BTB_K_HL)) begin
            instr_len = `BTB_LEN3;
          end else begin
            instr_len = `BTB_LEN4;
          end
        end
        `BTB_OP_DECREMENT_BRANCH_NONZERO: begin
          instr_len = (f_kind == `BTB_K_SADDR) ? `BTB_LEN3 : `BTB_LEN2;
        end
        `BTB_OP_NOP: instr_len = `BTB_LEN1;
        default:     instr_len = `BTB_LEN2;
      endcase
    end
  endfunction

  // Cycle count; fast selects the first column (fast RAM or no data access)
  function [4:0] instr_cycles;
    input [3:0] f_op;
    input [2:0] f_kind;
    input       f_fast;
    begin
      case (f_op)
        `BTB_OP_BT: begin
          case (f_kind)
            `BTB_K_SADDR: instr_cycles = f_fast ? `BTB_CYC8 : `BTB_CYC9;
            `BTB_K_SFR:   instr_cycles = `BTB_CYC11;
            `BTB_K_ACC:   instr_cycles = `BTB_CYC8;
            `BTB_K_PSW:   instr_cycles = `BTB_CYC9;
            default:      instr_cycles = f_fast ? `BTB_CYC10 : `BTB_CYC11;
          endcase
        end
        `BTB_OP_BF: begin
          case (f_kind)
            `BTB_K_ACC: instr_cycles = `BTB_CYC8;
            `BTB_K_SFR: instr_cycles = `BTB_CYC11;
            `BTB_K_PSW: instr_cycles = `BTB_CYC11;
            default:    instr_cycles = f_fast ? `BTB_CYC10 : `BTB_CYC11;
          endcase
        end
        `BTB_OP_BRANCH_SET_THEN_CLEAR: begin
          case (f_kind)
            `BTB_K_ACC: instr_cycles = `BTB_CYC8;
            `BTB_K_SFR: instr_cycles = `BTB_CYC12;
            `BTB_K_PSW: instr_cycles = `BTB_CYC12;
            default:    instr_cycles = f_fast ? `BTB_CYC10 : `BTB_CYC12;
          endcase
        end
        `BTB_OP_DECREMENT_BRANCH_NONZERO: begin
          if (f_kind == `BTB_K_SADDR) begin
            instr_cycles = f_fast ? `BTB_CYC8 : `BTB_CYC10;
          end else begin
            instr_cycles = `BTB_CYC6;
          end
        end
        `BTB_OP_SEL: instr_cycles = `BTB_CYC4;
        `BTB_OP_NOP: instr_cycles = `BTB_CYC2;
        default:     instr_cycles = `BTB_CYC6;
      endcase
    end
  endfunction

  // CPU clock ticks; the whole count runs in these periods
  btb_cpu_tick u_tick (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .div_sel_i (processor_clock_control),
    .tick_o    (tick)
  );

  // Standby modes block new requests until software wakes the core
  assign ready_o = ~busy & ~halt_mode & ~stop_mode;
  assign finish  = busy & tick & (cyc_cnt == `BTB_CYC2 - `BTB_CYC2 + 5'h01);

  // Displacement counts from the following instruction
  assign disp_ext = {{8{disp[7]}}, disp};
  assign seq_pc   = pc + instr_len(op, kind);

  // Operand byte, tested bit and the two modified values
  always @* begin
    case (kind)
      `BTB_K_ACC:  src = acc;
      `BTB_K_PSW:  src = program_status_word;
      `BTB_K_REGB: src = reg_b;
      `BTB_K_REGC: src = reg_c;
      default:     src = opr;
    endcase
    dec_val = src - 8'h01;
    clr_val = src & ~(8'h01 << bitn);
    case (op)
      `BTB_OP_BT:    taken = src[bitn];
      `BTB_OP_BF:    taken = ~src[bitn];
      `BTB_OP_BRANCH_SET_THEN_CLEAR: taken = src[bitn];
      `BTB_OP_DECREMENT_BRANCH_NONZERO:  taken = (dec_val != 8'h00);
      default:       taken = 1'b0;
    endcase
  end

  // Write-back of memory-resident operands goes out to the data bus
  always @* begin
    ext_wb      = 1'b0;
    ext_wb_data = `BTB_RST_BYTE;
    if ((kind == `BTB_K_SADDR) || (kind == `BTB_K_SFR) || (kind == `BTB_K_HL)) begin
      if ((op == `BTB_OP_BRANCH_SET_THEN_CLEAR) && taken) begin
        ext_wb      = 1'b1;
        ext_wb_data = clr_val;
      end else if ((op == `BTB_OP_DECREMENT_BRANCH_NONZERO) && (kind == `BTB_K_SADDR)) begin
        ext_wb      = 1'b1;
        ext_wb_data = dec_val;
      end
    end
  end

  // Next state: software writes first, finishing instruction overrides
  always @* begin
    next_acc   = acc;
    next_reg_b = reg_b;
    next_reg_c = reg_c;
    next_psw   = program_status_word;
    next_pc    = pc;
    next_halt  = halt_mode;
    next_stop  = stop_mode;
    if (reg_wr_i) begin
      case (reg_addr_i)
        `BTB_ADDR_ACC:  next_acc   = reg_wdata_i;
        `BTB_ADDR_REGB: next_reg_b = reg_wdata_i;
        `BTB_ADDR_REGC: next_reg_c = reg_wdata_i;
        `BTB_ADDR_PSW:  next_psw   = reg_wdata_i;
        `BTB_ADDR_PCL:  next_pc    = {pc[15:8], reg_wdata_i};
        `BTB_ADDR_PCH:  next_pc    = {reg_wdata_i, pc[7:0]};
        `BTB_ADDR_STAT: begin
          next_halt = 1'b0; // Any status write wakes the core
          next_stop = 1'b0;
        end
        default: begin
        end
      endcase
    end
    if (finish) begin
      next_pc = taken ? (seq_pc + disp_ext) : seq_pc;
      case (op)
        `BTB_OP_BRANCH_SET_THEN_CLEAR: begin
          if (taken && (kind == `BTB_K_ACC)) begin
            next_acc = clr_val;
          end
          if (taken && (kind == `BTB_K_PSW)) begin
            next_psw = clr_val;
          end
        end
        `BTB_OP_DECREMENT_BRANCH_NONZERO: begin
          if (kind == `BTB_K_REGB) begin
            next_reg_b = dec_val;
          end
          if (kind == `BTB_K_REGC) begin
            next_reg_c = dec_val;
          end
        end
        `BTB_OP_SEL: begin
          next_psw[`BTB_PSW_BANK1] = bitn[1];
          next_psw[`BTB_PSW_BANK0] = bitn[0];
        end
        `BTB_OP_EI:   next_psw[`BTB_PSW_IE] = 1'b1;
        `BTB_OP_DI:   next_psw[`BTB_PSW_IE] = 1'b0;
        `BTB_OP_HALT: next_halt = 1'b1;
        `BTB_OP_STOP: next_stop = 1'b1;
        default: begin
        end
      endcase
    end
  end

  // Request capture and CPU-cycle countdown
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      busy    <= 1'b0;
      op      <= `BTB_OP_NOP;
      kind    <= `BTB_K_SADDR;
      bitn    <= 3'h0;
      disp    <= `BTB_RST_BYTE;
      opr     <= `BTB_RST_BYTE;
      cyc_cnt <= 5'h00;
    end else if (req_i && ready_o) begin
      busy    <= 1'b1;
      op      <= req_op_i;
      kind    <= req_kind_i;
      bitn    <= req_bit_i;
      disp    <= req_disp_i;
      opr     <= req_opr_i;
      // Slower fetch sources pay a fixed penalty on top of the listed count
      cyc_cnt <= instr_cycles(req_op_i, req_kind_i, req_fast_ram_i)
                 + (req_rom_fetch_i ? 5'h00 : `BTB_EXT_FETCH);
    end else if (finish) begin
      busy    <= 1'b0;
      cyc_cnt <= 5'h00;
    end else if (busy && tick) begin
      cyc_cnt <= cyc_cnt - 5'h01;
    end
  end

  // Architectural registers
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      acc        <= `BTB_RST_BYTE;
      reg_b      <= `BTB_RST_BYTE;
      reg_c      <= `BTB_RST_BYTE;
      program_status_word        <= `BTB_RST_PSW;
      pc         <= `BTB_RST_PC;
      processor_clock_control        <= `BTB_RST_PCC;
      halt_mode  <= 1'b0;
      stop_mode  <= 1'b0;
      last_taken <= 1'b0;
    end else begin
      acc       <= next_acc;
      reg_b     <= next_reg_b;
      reg_c     <= next_reg_c;
      program_status_word       <= next_psw;
      pc        <= next_pc;
      halt_mode <= next_halt;
      stop_mode <= next_stop;
      if (reg_wr_i && (reg_addr_i == `BTB_ADDR_PCC)) begin
        processor_clock_control <= reg_wdata_i[2:0];
      end
      if (finish) begin
        last_taken <= taken;
      end
    end
  end

  // Completion pulse and write-back data, one cycle after the last tick
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      done_o    <= 1'b0;
      taken_o   <= 1'b0;
      wb_en_o   <= 1'b0;
      wb_data_o <= `BTB_RST_BYTE;
    end else begin
      done_o    <= finish;
      taken_o   <= finish & taken;
      wb_en_o   <= finish & ext_wb;
      if (finish) begin
        wb_data_o <= ext_wb_data;
      end
    end
  end

  // Read data stands only in the cycle after the read strobe
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= `BTB_RST_BYTE;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `BTB_ADDR_ACC:  reg_rdata_o <= acc;
        `BTB_ADDR_REGB: reg_rdata_o <= reg_b;
        `BTB_ADDR_REGC: reg_rdata_o <= reg_c;
        `BTB_ADDR_PSW:  reg_rdata_o <= program_status_word;
        `BTB_ADDR_PCC:  reg_rdata_o <= {5'h00, processor_clock_control};
        `BTB_ADDR_STAT: begin
          reg_rdata_o <= 8'h00;
          reg_rdata_o[`BTB_ST_BUSY]  <= busy;
          reg_rdata_o[`BTB_ST_HALT]  <= halt_mode;
          reg_rdata_o[`BTB_ST_STOP]  <= stop_mode;
          reg_rdata_o[`BTB_ST_TAKEN] <= last_taken;
        end
        `BTB_ADDR_PCL:  reg_rdata_o <= pc[7:0];
        `BTB_ADDR_PCH:  reg_rdata_o <= pc[15:8];
        default:        reg_rdata_o <= 8'h00; // Unmapped reads return zero
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  assign pc_o   = pc;
  assign psw_o  = program_status_word;
  assign halt_o = halt_mode;
  assign stop_o = stop_mode;

endmodule

/* btb_checker.sv */
`timescale 1ns/100ps
`include "btb_consts.vh"

module btb_checker (
  // Clock and reset
  input wire        mclk_i,
  input wire        rst_n_i,
  // Inputs watched
  input wire [3:0]  reg_addr_i,
  input wire [7:0]  reg_wdata_i,
  input wire        reg_wr_i,
  input wire        req_i,
  input wire [3:0]  req_op_i,
  input wire [2:0]  req_kind_i,
  input wire [2:0]  req_bit_i,
  input wire        req_rom_fetch_i,
  // Outputs watched
  input wire        ready_o,
  input wire        done_o,
  input wire        taken_o,
  input wire        wb_en_o,
  input wire [15:0] pc_o,
  input wire [7:0]  psw_o,
  input wire        halt_o,
  input wire        stop_o
);
  reg  pcc_fast;
  wire acc;

  // Exact counts hold only at full CPU rate with a ROM fetch
  assign acc = req_i && ready_o && pcc_fast && req_rom_fetch_i;

  // Mirror the clock select; the body is hidden so it is tracked from writes
  always @(posedge mclk_i) begin
    if (!rst_n_i)
      pcc_fast <= 1'b1;
    else if (reg_wr_i && reg_addr_i == `BTB_ADDR_PCC)
      pcc_fast <= (reg_wdata_i[2:0] == 3'h0);
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  done_pulse_a: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  taken_done_a: assert property (taken_o || wb_en_o |-> done_o)
    else $error("taken or write-back without done");
  nop_count_a: assert property (acc && req_op_i == `BTB_OP_NOP |=> !done_o [*2] ##1 done_o)
    else $error("no-op count wrong");
  rom_penalty_a: assert property (req_i && ready_o && pcc_fast && !req_rom_fetch_i
    && req_op_i == `BTB_OP_NOP |=> !done_o [*4] ##1 done_o)
    else $error("fetch penalty wrong");
  ie_set_a: assert property (acc && req_op_i == `BTB_OP_EI |-> ##7 done_o && psw_o[7])
    else $error("enable flag not set in 6");
  ie_clear_a: assert property (acc && req_op_i == `BTB_OP_DI |-> ##7 done_o && !psw_o[7])
    else $error("enable flag not cleared in 6");
  bank_sel_a: assert property (acc && req_op_i == `BTB_OP_SEL |-> ##5 done_o
    && psw_o[5] == $past(req_bit_i[1], 5) && psw_o[3] == $past(req_bit_i[0], 5))
    else $error("bank bits wrong");
  acc_bit_a: assert property (acc && req_op_i == `BTB_OP_BT
    && req_kind_i == `BTB_K_ACC |=> !done_o [*8] ##1 done_o)
    else $error("accumulator test count wrong");
  loop_reg_a: assert property (acc && req_op_i == `BTB_OP_DECREMENT_BRANCH_NONZERO
    && (req_kind_i == `BTB_K_REGB || req_kind_i == `BTB_K_REGC) |-> ##7 done_o && !wb_en_o)
    else $error("register loop count wrong");
  pc_move_a: assert property (!$stable(pc_o) |-> done_o || $past(reg_wr_i))
    else $error("pc moved without cause");
  standby_a: assert property (halt_o || stop_o |-> !ready_o)
    else $error("request open in standby");
endmodule

/* btb_tb.sv */
`timescale 1ns/100ps
`include "btb_consts.vh"
`define TB_CHK(g, e) begin compares = compares + 1; if ((g) !== (e)) begin error_cnt = error_cnt + 1; $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb;
  reg         mclk_i, rst_n_i, reg_wr_i, reg_rd_i, req_i, req_fast_ram_i, req_rom_fetch_i;
  reg  [3:0]  reg_addr_i, req_op_i;
  reg  [7:0]  reg_wdata_i, req_disp_i, req_opr_i, disp, opr;
  reg  [2:0]  req_kind_i, req_bit_i;
  reg         rom;
  reg  [15:0] pc_exp;
  wire [7:0]  reg_rdata_o, wb_data_o, psw_o;
  wire        ready_o, done_o, taken_o, wb_en_o, halt_o, stop_o;
  wire [15:0] pc_o;
  integer     error_cnt, compares, cyc_cnt, t_div;

  btb_exec i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .req_i(req_i), .req_op_i(req_op_i), .req_kind_i(req_kind_i),
    .req_bit_i(req_bit_i), .req_disp_i(req_disp_i), .req_opr_i(req_opr_i),
    .req_fast_ram_i(req_fast_ram_i), .req_rom_fetch_i(req_rom_fetch_i), .ready_o(ready_o),
    .done_o(done_o), .taken_o(taken_o), .wb_data_o(wb_data_o), .wb_en_o(wb_en_o),
    .pc_o(pc_o), .psw_o(psw_o), .halt_o(halt_o), .stop_o(stop_o));

  // 50 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge mclk_i) begin
    cyc_cnt = cyc_cnt + 1;
    if (cyc_cnt == 6000) begin
      error_cnt = error_cnt + 1;
      summarize;
    end
  end

  task summarize;
    begin
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  // Register port cycles
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge mclk_i);
      reg_wr_i    <= 1'b1;
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      @(posedge mclk_i);
      reg_wr_i    <= 1'b0;
    end
  endtask

  task rd(input [3:0] a, input [7:0] e);
    begin
      @(posedge mclk_i);
      reg_rd_i   <= 1'b1;
      reg_addr_i <= a;
      @(posedge mclk_i);
      reg_rd_i   <= 1'b0;
      #1;
      `TB_CHK(reg_rdata_o, e);
    end
  endtask

  // One instruction; counts edges from accept to done and checks the outcome
  task run(input [3:0] o, input [2:0] k, input [2:0] b, input f, input [4:0] n,
           input [15:0] len, input tk, input we);
    integer cnt;
    begin
      @(posedge mclk_i);
      req_i           <= 1'b1;
      req_op_i        <= o;
      req_kind_i      <= k;
      req_bit_i       <= b;
      req_disp_i      <= disp;
      req_opr_i       <= opr;
      req_fast_ram_i  <= f;
      req_rom_fetch_i <= rom;
      @(posedge mclk_i);
      req_i <= 1'b0;
      cnt = 0;
      do begin
        @(posedge mclk_i);
        #1;
        cnt = cnt + 1;
      end while (done_o !== 1'b1 && cnt < 200);
      `TB_CHK(cnt >= (n - 1) * t_div + 1 && cnt <= (t_div == 1 ? n : n * t_div + t_div), 1'b1);
      pc_exp = pc_exp + len + (tk ? {{8{disp[7]}}, disp} : 16'h0000);
      `TB_CHK({taken_o, wb_en_o, pc_o}, {tk, we, pc_exp});
      if (we) `TB_CHK(wb_data_o, (o == `BTB_OP_DECREMENT_BRANCH_NONZERO) ? opr - 8'h01 : opr & ~(8'h01 << b));
    end
  endtask

  // Reset values, unmapped place, program counter load
  task t_regs;
    begin
      rd(`BTB_ADDR_PSW, 8'h02);
      rd(`BTB_ADDR_STAT, 8'h00);
      wr(4'hF, 8'hFF);
      rd(4'hF, 8'h00);
      wr(`BTB_ADDR_PCL, 8'h34);
      wr(`BTB_ADDR_PCH, 8'h12);
      rd(`BTB_ADDR_PCL, 8'h34);
      pc_exp = 16'h1234;
      wr(`BTB_ADDR_ACC, 8'h05);
      $display("test regs done");
    end
  endtask

  // Every bit-test form, both columns for short address and BT HL, taken and not, backward jumps
  task t_bits;
    begin
      disp = 8'hF0;
      opr  = 8'h10;
      run(`BTB_OP_BT, `BTB_K_SADDR, 3'h4, 1'b1, 5'h08, 16'h3, 1'b1, 1'b0);
      run(`BTB_OP_BT, `BTB_K_SADDR, 3'h3, 1'b0, 5'h09, 16'h3, 1'b0, 1'b0);
      run(`BTB_OP_BT, `BTB_K_SFR, 3'h4, 1'b0, 5'h0B, 16'h4, 1'b1, 1'b0);
      run(`BTB_OP_BT, `BTB_K_ACC, 3'h0, 1'b1, 5'h08, 16'h3, 1'b1, 1'b0);
      run(`BTB_OP_BT, `BTB_K_PSW, 3'h1, 1'b0, 5'h09, 16'h3, 1'b1, 1'b0);
      run(`BTB_OP_BT, `BTB_K_HL, 3'h3, 1'b1, 5'h0A, 16'h3, 1'b0, 1'b0);
      run(`BTB_OP_BT, `BTB_K_HL, 3'h4, 1'b0, 5'h0B, 16'h3, 1'b1, 1'b0);
      run(`BTB_OP_BF, `BTB_K_SADDR, 3'h3, 1'b0, 5'h0B, 16'h4, 1'b1, 1'b0);
      run(`BTB_OP_BF, `BTB_K_SADDR, 3'h4, 1'b1, 5'h0A, 16'h4, 1'b0, 1'b0);
      run(`BTB_OP_BF, `BTB_K_SFR, 3'h4, 1'b0, 5'h0B, 16'h4, 1'b0, 1'b0);
      run(`BTB_OP_BF, `BTB_K_PSW, 3'h0, 1'b0, 5'h0B, 16'h4, 1'b1, 1'b0);
      run(`BTB_OP_BF, `BTB_K_ACC, 3'h1, 1'b1, 5'h08, 16'h3, 1'b1, 1'b0);
      run(`BTB_OP_BF, `BTB_K_HL, 3'h4, 1'b0, 5'h0B, 16'h3, 1'b0, 1'b0);
      run(`BTB_OP_BRANCH_SET_THEN_CLEAR, `BTB_K_SADDR, 3'h4, 1'b0, 5'h0C, 16'h4, 1'b1, 1'b1);
      run(`BTB_OP_BRANCH_SET_THEN_CLEAR, `BTB_K_SADDR, 3'h3, 1'b1, 5'h0A, 16'h4, 1'b0, 1'b0);
      run(`BTB_OP_BRANCH_SET_THEN_CLEAR, `BTB_K_HL, 3'h4, 1'b1, 5'h0A, 16'h3, 1'b1, 1'b1);
      run(`BTB_OP_BRANCH_SET_THEN_CLEAR, `BTB_K_SFR, 3'h3, 1'b0, 5'h0C, 16'h4, 1'b0, 1'b0);
      run(`BTB_OP_BRANCH_SET_THEN_CLEAR, `BTB_K_ACC, 3'h2, 1'b1, 5'h08, 16'h3, 1'b1, 1'b0);
      rd(`BTB_ADDR_ACC, 8'h01);
      run(`BTB_OP_BRANCH_SET_THEN_CLEAR, `BTB_K_PSW, 3'h1, 1'b0, 5'h0C, 16'h4, 1'b1, 1'b0);
      `TB_CHK(psw_o, 8'h00);
      rd(`BTB_ADDR_STAT, 8'h08);
      rd(`BTB_ADDR_PCH, pc_exp[15:8]);
      $display("test bits done");
    end
  endtask

  // Decrement loops, including wrap from zero
  task t_loops;
    begin
      disp = 8'h04;
      wr(`BTB_ADDR_REGB, 8'h02);
      run(`BTB_OP_DECREMENT_BRANCH_NONZERO, `BTB_K_REGB, 3'h0, 1'b1, 5'h06, 16'h2, 1'b1, 1'b0);
      run(`BTB_OP_DECREMENT_BRANCH_NONZERO, `BTB_K_REGB, 3'h0, 1'b1, 5'h06, 16'h2, 1'b0, 1'b0);
      rd(`BTB_ADDR_REGB, 8'h00);
      wr(`BTB_ADDR_REGC, 8'h00);
      run(`BTB_OP_DECREMENT_BRANCH_NONZERO, `BTB_K_REGC, 3'h0, 1'b1, 5'h06, 16'h2, 1'b1, 1'b0);
      rd(`BTB_ADDR_REGC, 8'hFF);
      opr = 8'h01;
      run(`BTB_OP_DECREMENT_BRANCH_NONZERO, `BTB_K_SADDR, 3'h0, 1'b1, 5'h08, 16'h3, 1'b0, 1'b1);
      opr = 8'h00;
      run(`BTB_OP_DECREMENT_BRANCH_NONZERO, `BTB_K_SADDR, 3'h0, 1'b0, 5'h0A, 16'h3, 1'b1, 1'b1);
      $display("test loops done");
    end
  endtask

  // Standby entry, a refused request, then release by a status write
  task standby(input [3:0] o, input [1:0] flag);
    begin
      run(o, `BTB_K_SADDR, 3'h0, 1'b1, 5'h06, 16'h2, 1'b0, 1'b0);
      `TB_CHK({stop_o, halt_o, ready_o}, {flag, 1'b0});
      @(posedge mclk_i);
      req_i    <= 1'b1;
      req_op_i <= `BTB_OP_NOP;
      repeat (4) @(posedge mclk_i);
      #1;
      `TB_CHK({done_o, ready_o}, 2'b00);
      @(posedge mclk_i);
      req_i <= 1'b0;
      wr(`BTB_ADDR_STAT, 8'h00);
      #1;
      `TB_CHK({stop_o, halt_o, pc_o}, {2'b00, pc_exp});
    end
  endtask

  // Control group, slow fetch and a divided CPU clock
  task t_ctrl;
    begin
      run(`BTB_OP_SEL, `BTB_K_SADDR, 3'h2, 1'b1, 5'h04, 16'h2, 1'b0, 1'b0);
      `TB_CHK(psw_o, 8'h20);
      run(`BTB_OP_EI, `BTB_K_SADDR, 3'h0, 1'b0, 5'h06, 16'h2, 1'b0, 1'b0);
      `TB_CHK(psw_o, 8'hA0);
      run(`BTB_OP_DI, `BTB_K_SADDR, 3'h0, 1'b0, 5'h06, 16'h2, 1'b0, 1'b0);
      `TB_CHK(psw_o, 8'h20);
      run(`BTB_OP_NOP, `BTB_K_SADDR, 3'h0, 1'b1, 5'h02, 16'h1, 1'b0, 1'b0);
      rom = 1'b0;
      run(`BTB_OP_NOP, `BTB_K_SADDR, 3'h0, 1'b1, 5'h04, 16'h1, 1'b0, 1'b0);
      rom = 1'b1;
      wr(`BTB_ADDR_PCC, 8'h02);
      t_div = 4;
      run(`BTB_OP_NOP, `BTB_K_SADDR, 3'h0, 1'b1, 5'h02, 16'h1, 1'b0, 1'b0);
      wr(`BTB_ADDR_PCC, 8'h00);
      t_div = 1;
      standby(`BTB_OP_HALT, 2'b01);
      standby(`BTB_OP_STOP, 2'b10);
      $display("test ctrl done");
    end
  endtask

  // Main sequence
  initial begin
    error_cnt = 0;
    compares  = 0;
    cyc_cnt   = 0;
    t_div     = 1;
    pc_exp    = 16'h0000;
    disp      = 8'h00;
    opr       = 8'h00;
    rom       = 1'b1;
    rst_n_i   = 1'b0;
    reg_wr_i  = 1'b0;
    reg_rd_i  = 1'b0;
    reg_addr_i  = 4'h0;
    reg_wdata_i = 8'h00;
    req_i       = 1'b0;
    req_op_i    = 4'h0;
    req_kind_i  = 3'h0;
    req_bit_i   = 3'h0;
    req_disp_i  = 8'h00;
    req_opr_i   = 8'h00;
    req_fast_ram_i  = 1'b1;
    req_rom_fetch_i = 1'b1;
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_regs;
    t_bits;
    t_loops;
    t_ctrl;
    summarize;
  end
endmodule

bind btb_exec btb_checker i_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .req_i(req_i),
  .req_op_i(req_op_i), .req_kind_i(req_kind_i), .req_bit_i(req_bit_i),
  .req_rom_fetch_i(req_rom_fetch_i), .ready_o(ready_o), .done_o(done_o), .taken_o(taken_o),
  .wb_en_o(wb_en_o), .pc_o(pc_o), .psw_o(psw_o), .halt_o(halt_o), .stop_o(stop_o));
